/* File: logic/csp_pkg.sv */
package csp_pkg;

  localparam int CSP_AW = 16;
  localparam int CSP_DW = 16;

  // Setup words
  localparam logic [15:0] CSP_ADDR_TAG_COMM = 16'h19d3;
  localparam logic [15:0] CSP_ADDR_SERIAL_SVC = 16'h19d8;
  localparam logic [15:0] CSP_ADDR_PERIPH_SVC = 16'h19d9;
  localparam logic [15:0] CSP_ADDR_CYCLE_MON = 16'h19da;
  localparam logic [15:0] CSP_ADDR_MIN_CYCLE = 16'h19db;
  localparam logic [15:0] CSP_ADDR_FILTER = 16'h19dc;
  localparam logic [15:0] CSP_ADDR_INT_EN = 16'h19e4;
  localparam logic [15:0] CSP_ADDR_FAST_TMR = 16'h19e5;
  localparam logic [15:0] CSP_ADDR_INT0_REFRESH = 16'h19e6;
  localparam logic [15:0] CSP_ADDR_INT1_REFRESH = 16'h19e7;
  // Block status and control
  localparam logic [15:0] CSP_ADDR_STATUS = 16'h19f0;
  localparam logic [15:0] CSP_ADDR_CLEAR = 16'h19f1;
  localparam logic [15:0] CSP_ADDR_ENABLE = 16'h19f2;
  localparam logic [15:0] CSP_ADDR_CONTROL = 16'h19f3;

  localparam logic [15:0] CSP_WORD_RESET = 16'h0000;
  localparam logic [15:0] CSP_MIN_CYCLE_RESET = 16'h0000;

  // Byte and nibble codes
  localparam logic [7:0] CSP_ENA_OFF = 8'h00;
  localparam logic [7:0] CSP_ENA_ON = 8'h01;
  localparam logic [7:0] CSP_MON_UNIT_10MS = 8'h01;
  localparam logic [7:0] CSP_MON_UNIT_100MS = 8'h02;
  localparam logic [7:0] CSP_MON_UNIT_1S = 8'h03;
  localparam logic [7:0] CSP_REFRESH_ON = 8'h00;
  localparam logic [3:0] CSP_NIB_INTERRUPT = 4'h1;
  localparam logic [3:0] CSP_RESP_INTERRUPT = 4'h1;

  // Field positions
  localparam int CSP_RESP_LSB = 4;
  localparam int CSP_BYTE_HI_LSB = 8;
  localparam int CSP_FILT_HI_LSB = 4;
  localparam int CSP_NUM_INT_IN = 4;

  // Defaults and limits in their own units
  localparam logic [6:0] CSP_SERIAL_DEFAULT_PCT = 7'h05;
  localparam logic [7:0] CSP_PERIPH_DEFAULT_MS = 8'h78;
  localparam logic [16:0] CSP_MON_DEFAULT_MS = 17'h00078;
  localparam logic [16:0] CSP_MON_10MS = 17'h0000a;
  localparam logic [16:0] CSP_MON_100MS = 17'h00064;
  localparam logic [16:0] CSP_MON_1S = 17'h003e8;
  localparam logic [4:0] CSP_FAST_TIMERS_ALL = 5'h10;
  localparam logic [16:0] CSP_ELAPSED_MAX = 17'h1ffff;

  // Timing
  localparam int CSP_CLK_PERIOD_NS = 40;
  localparam int CSP_MS_NS = 1000000;
  localparam int CSP_MS_CYCLES = CSP_MS_NS / CSP_CLK_PERIOD_NS;

  // Status and control bits
  localparam int CSP_ST_OVERRUN = 0;
  localparam int CSP_ST_SCAN_END = 1;
  localparam int CSP_NUM_EVENTS = 2;
  localparam int CSP_CTRL_START = 0;
  localparam int CSP_CTRL_STOP = 1;
  localparam int CSP_CTRL_RESTART = 2;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csp_bus_req_t;

  typedef struct packed {
    logic resp_irq_mode;
    logic [6:0] serial_pct;
    logic periph_by_pct;
    logic [6:0] periph_pct;
    logic [7:0] filter_lo_ms;
    logic [7:0] filter_hi_ms;
    logic [3:0] int_input_en;
    logic [4:0] fast_timer_count;
    logic [1:0] int_refresh_en;
  } csp_cfg_t;

  typedef enum logic [1:0] {
    CSP_STOPPED,
    CSP_SCAN,
    CSP_PAD
  } csp_state_t;

  function automatic logic [7:0] csp_filter_ms(input logic [3:0] code);
    logic [7:0] ms;
    ms = 8'h08;
    if (code >= 4'h1 && code <= 4'h8) begin
      ms = 8'h01 << (code - 4'h1);
    end
    return ms;
  endfunction : csp_filter_ms

endpackage : csp_pkg

/* File: logic/csp_bcd2bin.sv */
`timescale 1ns/10ps
module csp_bcd2bin #(
  parameter int DIGITS = 2,
  parameter int BW = 7
) (
  input wire logic [4*DIGITS-1:0] bcd,
  output logic [BW-1:0] bin
);
  // Digits above nine are not clamped; software is expected to write true BCD
  always_comb begin
    bin = '0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      bin = BW'(bin * BW'(10) + BW'(bcd[4*i +: 4]));
    end
  end
endmodule : csp_bcd2bin

/* File: logic/csp_bank.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module csp_bank
  import csp_pkg::*;
#(
  parameter int MS_CYCLES = CSP_MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire csp_bus_req_t bus,
  output logic [15:0] rdata_q,
  input wire logic scan_work_done,
  output logic scan_begin_q,
  output logic running_q,
  output logic overrun_q,
  output csp_cfg_t cfg_q,
  output logic irq_q
);

  // Software-side words
  logic [15:0] tag_comm_setup_q;
  logic [15:0] serial_port_service_time_q;
  logic [15:0] peripheral_port_service_time_q;
  logic [15:0] cycle_monitor_time_q;
  logic [15:0] minimum_cycle_time_q;
  logic [15:0] input_filter_constants_q;
  logic [15:0] input_interrupt_enables_q;
  logic [15:0] fast_timer_refresh_count_q;
  logic [15:0] interrupt0_input_refresh_q;
  logic [15:0] interrupt1_input_refresh_q;

  logic [CSP_NUM_EVENTS-1:0] status_q;
  logic [CSP_NUM_EVENTS-1:0] irq_enable_q;

  // Values in force for the scan engine
  logic [16:0] mon_limit_q;
  logic [13:0] min_cycle_q;
  csp_state_t state_q;
  csp_state_t state_d;
  logic [15:0] prescale_q;
  logic [16:0] elapsed_q;

  // Address decode
  // Exact decode: each word answers at one address only
  wire sel_tag = bus.addr == CSP_ADDR_TAG_COMM;
  wire sel_serial = bus.addr == CSP_ADDR_SERIAL_SVC;
  wire sel_periph = bus.addr == CSP_ADDR_PERIPH_SVC;
  wire sel_mon = bus.addr == CSP_ADDR_CYCLE_MON;
  wire sel_min = bus.addr == CSP_ADDR_MIN_CYCLE;
  wire sel_filter = bus.addr == CSP_ADDR_FILTER;
  wire sel_int_en = bus.addr == CSP_ADDR_INT_EN;
  wire sel_fast = bus.addr == CSP_ADDR_FAST_TMR;
  wire sel_ref0 = bus.addr == CSP_ADDR_INT0_REFRESH;
  wire sel_ref1 = bus.addr == CSP_ADDR_INT1_REFRESH;
  wire sel_status = bus.addr == CSP_ADDR_STATUS;
  wire sel_clear = bus.addr == CSP_ADDR_CLEAR;
  wire sel_enable = bus.addr == CSP_ADDR_ENABLE;
  wire sel_ctrl = bus.addr == CSP_ADDR_CONTROL;

  // Control writes act as one-cycle commands; nothing of them is stored
  wire ctrl_wr = bus.wr && sel_ctrl;
  wire start_cmd = ctrl_wr && bus.wdata[CSP_CTRL_START];
  wire stop_cmd = ctrl_wr && bus.wdata[CSP_CTRL_STOP];
  wire restart_cmd = ctrl_wr && bus.wdata[CSP_CTRL_RESTART];

  // Read multiplexer; unmapped and write-only addresses read zero
  // Reserved bits of every setup word are stored and read back as written
  wire [15:0] ctrl_rd_word = {14'h0000, overrun_q, running_q};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      sel_tag: rd_mux = tag_comm_setup_q;
      sel_serial: rd_mux = serial_port_service_time_q;
      sel_periph: rd_mux = peripheral_port_service_time_q;
      sel_mon: rd_mux = cycle_monitor_time_q;
      sel_min: rd_mux = minimum_cycle_time_q;
      sel_filter: rd_mux = input_filter_constants_q;
      sel_int_en: rd_mux = input_interrupt_enables_q;
      sel_fast: rd_mux = fast_timer_refresh_count_q;
      sel_ref0: rd_mux = interrupt0_input_refresh_q;
      sel_ref1: rd_mux = interrupt1_input_refresh_q;
      sel_status: rd_mux = 16'(status_q);
      sel_enable: rd_mux = 16'(irq_enable_q);
      sel_ctrl: rd_mux = ctrl_rd_word;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 16'h0000;
    end
  end

  // Setup word storage; writes only land here, nothing in force changes yet
  always_ff @(posedge clock) begin
    if (rst) begin
      tag_comm_setup_q <= CSP_WORD_RESET;
      serial_port_service_time_q <= CSP_WORD_RESET;
      peripheral_port_service_time_q <= CSP_WORD_RESET;
      cycle_monitor_time_q <= CSP_WORD_RESET;
      minimum_cycle_time_q <= CSP_MIN_CYCLE_RESET;
      input_filter_constants_q <= CSP_WORD_RESET;
      input_interrupt_enables_q <= CSP_WORD_RESET;
      fast_timer_refresh_count_q <= CSP_WORD_RESET;
      interrupt0_input_refresh_q <= CSP_WORD_RESET;
      interrupt1_input_refresh_q <= CSP_WORD_RESET;
    end else if (bus.wr) begin
      if (sel_tag) tag_comm_setup_q <= bus.wdata;
      if (sel_serial) serial_port_service_time_q <= bus.wdata;
      if (sel_periph) peripheral_port_service_time_q <= bus.wdata;
      if (sel_mon) cycle_monitor_time_q <= bus.wdata;
      if (sel_min) minimum_cycle_time_q <= bus.wdata;
      if (sel_filter) input_filter_constants_q <= bus.wdata;
      if (sel_int_en) input_interrupt_enables_q <= bus.wdata;
      if (sel_fast) fast_timer_refresh_count_q <= bus.wdata;
      if (sel_ref0) interrupt0_input_refresh_q <= bus.wdata;
      if (sel_ref1) interrupt1_input_refresh_q <= bus.wdata;
    end
  end

  // BCD fields
  logic [6:0] serial_bcd_val;
  logic [6:0] periph_bcd_val;
  logic [6:0] mon_bcd_val;
  logic [6:0] fast_bcd_val;
  logic [13:0] min_bcd_val;

  csp_bcd2bin #(.DIGITS(2), .BW(7)) u_serial_bcd (
    .bcd(serial_port_service_time_q[7:0]),
    .bin(serial_bcd_val)
  );
  csp_bcd2bin #(.DIGITS(2), .BW(7)) u_periph_bcd (
    .bcd(peripheral_port_service_time_q[7:0]),
    .bin(periph_bcd_val)
  );
  csp_bcd2bin #(.DIGITS(2), .BW(7)) u_mon_bcd (
    .bcd(cycle_monitor_time_q[7:0]),
    .bin(mon_bcd_val)
  );
  csp_bcd2bin #(.DIGITS(2), .BW(7)) u_fast_bcd (
    .bcd(fast_timer_refresh_count_q[7:0]),
    .bin(fast_bcd_val)
  );
  // Four BCD digits reach 9999, which fits in 14 bits
  csp_bcd2bin #(.DIGITS(4), .BW(14)) u_min_bcd (
    .bcd(minimum_cycle_time_q),
    .bin(min_bcd_val)
  );

  // Decoded settings, waiting for the next start
  wire [7:0] serial_ena = serial_port_service_time_q[15:CSP_BYTE_HI_LSB];
  wire [7:0] periph_ena = peripheral_port_service_time_q[15:CSP_BYTE_HI_LSB];
  wire [7:0] mon_unit = cycle_monitor_time_q[15:CSP_BYTE_HI_LSB];
  wire [7:0] fast_ena = fast_timer_refresh_count_q[15:CSP_BYTE_HI_LSB];

  wire [6:0] serial_pct_d = (serial_ena == CSP_ENA_ON) ? serial_bcd_val
                                                        : CSP_SERIAL_DEFAULT_PCT;
  wire periph_by_pct_d = periph_ena == CSP_ENA_ON;
  wire [6:0] periph_pct_d = periph_by_pct_d ? periph_bcd_val : 7'h00;
  // Counts above 31 are cut to five bits; only 00 to 15 are meaningful
  wire [4:0] fast_count_d = (fast_ena == CSP_ENA_ON) ? fast_bcd_val[4:0]
                                                      : CSP_FAST_TIMERS_ALL;
  // Codes 9 to 15 fall back to 8 ms, like code 0
  wire [7:0] filt_lo_d = csp_filter_ms(input_filter_constants_q[3:0]);
  wire [7:0] filt_hi_d = csp_filter_ms(input_filter_constants_q[CSP_FILT_HI_LSB +: 4]);

  // One nibble per input; any code but 1 leaves the input normal
  logic [3:0] int_en_d;
  always_comb begin
    for (int i = 0; i < CSP_NUM_INT_IN; i++) begin
      int_en_d[i] = input_interrupt_enables_q[4*i +: 4] == CSP_NIB_INTERRUPT;
    end
  end

  // Only 00 refreshes; any other high byte skips the refresh
  wire [1:0] refresh_d = {
    interrupt1_input_refresh_q[15:CSP_BYTE_HI_LSB] == CSP_REFRESH_ON,
    interrupt0_input_refresh_q[15:CSP_BYTE_HI_LSB] == CSP_REFRESH_ON
  };

  // Unknown unit codes fall back to the default limit
  // The largest product, 99 s in ms, still fits in 17 bits
  logic [16:0] mon_limit_d;
  always_comb begin
    unique case (mon_unit)
      CSP_MON_UNIT_10MS: mon_limit_d = 17'(17'(mon_bcd_val) * CSP_MON_10MS);
      CSP_MON_UNIT_100MS: mon_limit_d = 17'(17'(mon_bcd_val) * CSP_MON_100MS);
      CSP_MON_UNIT_1S: mon_limit_d = 17'(17'(mon_bcd_val) * CSP_MON_1S);
      default: mon_limit_d = CSP_MON_DEFAULT_MS;
    endcase
  end

  wire resp_irq_mode_d = tag_comm_setup_q[CSP_RESP_LSB +: 4] == CSP_RESP_INTERRUPT;

  // Port, cycle and interrupt groups load when operation starts; the startup
  // group loads only on a restart, so a plain stop and start leaves it alone
  wire apply_run = start_cmd && !restart_cmd && state_q == CSP_STOPPED;
  always_ff @(posedge clock) begin
    if (rst) begin
      // Reset leaves every setting in force at its default
      cfg_q.resp_irq_mode <= 1'b0;
      cfg_q.serial_pct <= CSP_SERIAL_DEFAULT_PCT;
      cfg_q.periph_by_pct <= 1'b0;
      cfg_q.periph_pct <= 7'h00;
      cfg_q.filter_lo_ms <= csp_filter_ms(4'h0);
      cfg_q.filter_hi_ms <= csp_filter_ms(4'h0);
      cfg_q.int_input_en <= 4'h0;
      cfg_q.fast_timer_count <= CSP_FAST_TIMERS_ALL;
      cfg_q.int_refresh_en <= 2'h3;
      mon_limit_q <= CSP_MON_DEFAULT_MS;
      min_cycle_q <= 14'h0000;
    end else begin
      if (restart_cmd) begin
        cfg_q.resp_irq_mode <= resp_irq_mode_d;
      end
      if (apply_run) begin
        cfg_q.serial_pct <= serial_pct_d;
        cfg_q.periph_by_pct <= periph_by_pct_d;
        cfg_q.periph_pct <= periph_pct_d;
        cfg_q.filter_lo_ms <= filt_lo_d;
        cfg_q.filter_hi_ms <= filt_hi_d;
        cfg_q.int_input_en <= int_en_d;
        cfg_q.fast_timer_count <= fast_count_d;
        cfg_q.int_refresh_en <= refresh_d;
        mon_limit_q <= mon_limit_d;
        min_cycle_q <= min_bcd_val;
      end
    end
  end

  // Millisecond time base, restarted with each scan
  // Held at zero while stopped, so the first millisecond of a scan is a whole one
  wire ms_tick = prescale_q == 16'(MS_CYCLES - 1);
  wire scan_begin_d;
  always_ff @(posedge clock) begin
    if (rst || scan_begin_d || state_q == CSP_STOPPED) begin
      prescale_q <= 16'h0000;
    end else begin
      prescale_q <= ms_tick ? 16'h0000 : 16'(prescale_q + 16'h0001);
    end
  end

  // Saturates instead of wrapping, so a hung scan still trips the monitor
  always_ff @(posedge clock) begin
    if (rst || scan_begin_d || state_q == CSP_STOPPED) begin
      elapsed_q <= 17'h00000;
    end else if (ms_tick && elapsed_q != CSP_ELAPSED_MAX) begin
      elapsed_q <= 17'(elapsed_q + 17'h00001);
    end
  end

  // A zero minimum is always met, so the cycle runs free
  wire min_met = elapsed_q >= 17'(min_cycle_q);
  // The monitor watches the scan itself; padding time never counts as overrun
  wire overrun = state_q == CSP_SCAN && elapsed_q > mon_limit_q;

  // Stop and restart override every other transition
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CSP_STOPPED: if (apply_run) state_d = CSP_SCAN;
      CSP_SCAN: begin
        if (overrun) begin
          state_d = CSP_STOPPED;
        end else if (scan_work_done && !min_met) begin
          state_d = CSP_PAD;
        end
      end
      CSP_PAD: if (min_met) state_d = CSP_SCAN;
      default: state_d = CSP_STOPPED;
    endcase
    if (stop_cmd || restart_cmd) state_d = CSP_STOPPED;
  end

  // A start opens a scan at once; later scans need the work done and the minimum met
  assign scan_begin_d = state_d == CSP_SCAN &&
                        (state_q != CSP_SCAN || (scan_work_done && min_met && !overrun));

  // running_q mirrors state_q, so a control read never sees a half-started scan
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= CSP_STOPPED;
      scan_begin_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      state_q <= state_d;
      scan_begin_q <= scan_begin_d;
      running_q <= state_d != CSP_STOPPED;
    end
  end

  // Error flag holds until a new start; the set wins over that clear
  always_ff @(posedge clock) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (overrun) begin
      overrun_q <= 1'b1;
    end else if (apply_run) begin
      overrun_q <= 1'b0;
    end
  end

  // Sticky events; a same-cycle event beats the software clear
  // Done pulses while stopped or padding raise no event
  wire scan_end_evt = state_q == CSP_SCAN && scan_work_done;
  wire [CSP_NUM_EVENTS-1:0] events;
  assign events[CSP_ST_OVERRUN] = overrun;
  assign events[CSP_ST_SCAN_END] = scan_end_evt;
  wire clear_wr = bus.wr && sel_clear;
  wire enable_wr = bus.wr && sel_enable;
  wire [CSP_NUM_EVENTS-1:0] clear_mask = clear_wr ? bus.wdata[CSP_NUM_EVENTS-1:0] : '0;
  wire [CSP_NUM_EVENTS-1:0] status_d = (status_q & ~clear_mask) | events;
  wire [CSP_NUM_EVENTS-1:0] irq_enable_d = enable_wr ? bus.wdata[CSP_NUM_EVENTS-1:0] : irq_enable_q;
  // Built from next status and enable so the level never lags the bits it reports
  wire irq_d = |(status_d & irq_enable_d);

  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= '0;
      irq_enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_enable_q <= irq_enable_d;
      irq_q <= irq_d;
    end
  end

endmodule : csp_bank

/* File: verification/csp_bank_asserts.sv */
`timescale 1ns/10ps
module csp_bank_asserts
  import csp_pkg::*;
#(
  parameter int MS_CYCLES = CSP_MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire csp_bus_req_t bus,
  input wire logic [15:0] rdata_q,
  input wire logic scan_work_done,
  input wire logic scan_begin_q,
  input wire logic running_q,
  input wire logic overrun_q,
  input wire csp_cfg_t cfg_q,
  input wire logic irq_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  wire ctrl_wr = bus.wr && (bus.addr == CSP_ADDR_CONTROL);
  wire restart_req = ctrl_wr && bus.wdata[CSP_CTRL_RESTART];
  wire start_req = ctrl_wr && bus.wdata[CSP_CTRL_START] && !bus.wdata[CSP_CTRL_RESTART];

  sequence s_start_taken;
    start_req && !running_q;
  endsequence
  sequence s_scan_opens;
    scan_begin_q && running_q ##1 !scan_begin_q;
  endsequence

  property p_start;
    s_start_taken |=> s_scan_opens;
  endproperty
  a_start: assert property (p_start) else $error("start did not open a scan");

  property p_cfg_hold;
    running_q && !ctrl_wr |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed while running");

  property p_resp_hold;
    !restart_req |=> $stable(cfg_q.resp_irq_mode);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response mode changed without restart");

  property p_restart;
    restart_req |=> !running_q && !scan_begin_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart left operation running");

  property p_overrun_stop;
    $rose(overrun_q) |-> !running_q;
  endproperty
  a_overrun_stop: assert property (p_overrun_stop) else $error("overrun did not stop operation");

  property p_overrun_hold;
    overrun_q && !ctrl_wr |=> overrun_q;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun flag dropped early");

  property p_reset_cfg;
    $fell(rst) |-> cfg_q == csp_cfg_t'{1'b0, 7'h05, 1'b0, 7'h00, 8'h08, 8'h08, 4'h0, 5'h10, 2'b11};
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("settings not at defaults after reset");

  property p_rd_idle;
    !bus.rd |=> rdata_q == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero after idle cycle");
endmodule : csp_bank_asserts

bind csp_bank csp_bank_asserts #(.MS_CYCLES(MS_CYCLES)) u_asserts (.clock(clock), .rst(rst), .bus(bus),
  .rdata_q(rdata_q), .scan_work_done(scan_work_done), .scan_begin_q(scan_begin_q), .running_q(running_q),
  .overrun_q(overrun_q), .cfg_q(cfg_q), .irq_q(irq_q));

/* File: verification/csp_bank_tb.sv */
`timescale 1ns/10ps
module csp_bank_tb;
  import csp_pkg::*;
  localparam int MSC = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  csp_bus_req_t bus = '0;
  logic swd = 1'b0;
  logic [15:0] rdata_q;
  logic scan_begin_q;
  logic running_q;
  logic overrun_q;
  logic irq_q;
  csp_cfg_t cfg_q;
  csp_cfg_t e;
  int n_errors = 0;
  int check_count = 0;
  int c;
  logic [15:0] mon_w [4] = '{16'h0000, 16'h0102, 16'h0201, 16'h0301};
  int mon_ms [4] = '{120, 20, 100, 1000};

  always #20 clock = ~clock;

  csp_bank #(.MS_CYCLES(MSC)) dut (.clock(clock), .rst(rst), .bus(bus), .rdata_q(rdata_q),
    .scan_work_done(swd), .scan_begin_q(scan_begin_q), .running_q(running_q), .overrun_q(overrun_q),
    .cfg_q(cfg_q), .irq_q(irq_q));

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk(name, exp, rdata_q);
  endtask : rd

  // Counts settled cycles until a scan begins or the monitor trips
  task automatic count_to(input bit ovr, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (((ovr ? overrun_q : scan_begin_q) !== 1'b1) && n < 6000);
  endtask : count_to

  task automatic pulse_done();
    @(posedge clock);
    swd <= 1'b1;
    @(posedge clock);
    swd <= 1'b0;
  endtask : pulse_done

  task automatic load(input logic [15:0] s, input logic [15:0] p, input logic [15:0] f, input logic [15:0] ie,
                      input logic [15:0] ft, input logic [15:0] r0, input logic [15:0] r1, input logic [15:0] mc);
    wr(CSP_ADDR_SERIAL_SVC, s);
    wr(CSP_ADDR_PERIPH_SVC, p);
    wr(CSP_ADDR_FILTER, f);
    wr(CSP_ADDR_INT_EN, ie);
    wr(CSP_ADDR_FAST_TMR, ft);
    wr(CSP_ADDR_INT0_REFRESH, r0);
    wr(CSP_ADDR_INT1_REFRESH, r1);
    wr(CSP_ADDR_MIN_CYCLE, mc);
  endtask : load

  task automatic summarize();
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    e = '{1'b0, 7'h05, 1'b0, 7'h00, 8'h08, 8'h08, 4'h0, 5'h10, 2'b11};
    #1 chk("cfg_reset", e, cfg_q);
    rd(CSP_ADDR_MIN_CYCLE, 16'h0000, "min_cycle_reset");
    wr(16'h19e0, 16'hffff);
    rd(16'h19e0, 16'h0000, "unmapped");
    rd(CSP_ADDR_CLEAR, 16'h0000, "clear_read");
    wr(CSP_ADDR_TAG_COMM, 16'h0010);
    load(16'h0142, 16'h0137, 16'h0083, 16'h1001, 16'h0115, 16'h0100, 16'h0000, 16'h0003);
    rd(CSP_ADDR_FAST_TMR, 16'h0115, "fast_tmr_word");
    #1 chk("cfg_before_start", e, cfg_q);
    wr(CSP_ADDR_CONTROL, 16'h0001);
    #1 chk("scan_begin", 1'b1, scan_begin_q);
    e = '{1'b0, 7'h2a, 1'b1, 7'h25, 8'h04, 8'h80, 4'h9, 5'h0f, 2'b10};
    chk("cfg_start_a", e, cfg_q);
    pulse_done();
    count_to(1'b0, c);
    // Two cycles already spent raising the done pulse
    chk("min_cycle_wait", 1'b1, (c + 2 >= 3 * MSC) && (c + 2 <= 3 * MSC + 4));
    rd(CSP_ADDR_STATUS, 16'h0002, "status_scan_end");
    chk("irq_masked", 1'b0, irq_q);
    wr(CSP_ADDR_ENABLE, 16'h0002);
    @(posedge clock);
    #1 chk("irq_raised", 1'b1, irq_q);
    rd(CSP_ADDR_ENABLE, 16'h0002, "enable_read");
    wr(CSP_ADDR_CLEAR, 16'h0002);
    @(posedge clock);
    #1 chk("irq_cleared", 1'b0, irq_q);
    wr(CSP_ADDR_CONTROL, 16'h0004);
    #1 chk("restart_stops", 1'b0, running_q);
    chk("resp_mode", 1'b1, cfg_q.resp_irq_mode);
    load(16'h0042, 16'h0037, 16'h0010, 16'h0000, 16'h0015, 16'h0000, 16'h0100, 16'h0000);
    wr(CSP_ADDR_CONTROL, 16'h0001);
    e = '{1'b1, 7'h05, 1'b0, 7'h00, 8'h08, 8'h01, 4'h0, 5'h10, 2'b01};
    #1 chk("cfg_start_b", e, cfg_q);
    pulse_done();
    #1 chk("no_min_cycle", 1'b1, scan_begin_q);
    rd(CSP_ADDR_CONTROL, 16'h0001, "ctrl_running");
    wr(CSP_ADDR_ENABLE, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(CSP_ADDR_CONTROL, 16'h0002);
      wr(CSP_ADDR_CLEAR, 16'h0003);
      wr(CSP_ADDR_CYCLE_MON, mon_w[i]);
      wr(CSP_ADDR_CONTROL, 16'h0001);
      #1 chk("overrun_cleared", 1'b0, overrun_q);
      count_to(1'b1, c);
      chk("overrun_flag", 1'b1, overrun_q);
      chk("monitor_limit", 1'b1, (c >= mon_ms[i] * MSC) && (c <= (mon_ms[i] + 2) * MSC));
      chk("overrun_stops", 1'b0, running_q);
      rd(CSP_ADDR_STATUS, 16'h0001, "status_overrun");
      chk("irq_overrun", 1'b1, irq_q);
      rd(CSP_ADDR_CONTROL, 16'h0002, "ctrl_overrun");
    end
    // Reset again in mid-run, with a scan just started
    wr(CSP_ADDR_CONTROL, 16'h0001);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    e = '{1'b0, 7'h05, 1'b0, 7'h00, 8'h08, 8'h08, 4'h0, 5'h10, 2'b11};
    #1 chk("cfg_rerst", e, cfg_q);
    chk("outs_rerst", 4'h0, {scan_begin_q, running_q, overrun_q, irq_q});
    rd(CSP_ADDR_TAG_COMM, 16'h0000, "tag_rerst");
    rd(CSP_ADDR_MIN_CYCLE, 16'h0000, "min_cycle_rerst");
    summarize();
  end

  // The longest monitor case needs about 4000 cycles; the rest add well under that
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
endmodule : csp_bank_tb
